// ### rtl/tsfw_pkg.sv
// package: constants and types for the task status flag word
package tsfw_pkg;
  localparam logic [11:0] TSFW_STATUS_OFF = 12'h000;
  localparam logic [11:0] TSFW_CODE_OFF = 12'h004;
  localparam logic [11:0] TSFW_MODE_OFF = 12'h008;
  localparam logic [11:0] TSFW_CMD_OFF = 12'h00c;
  localparam logic [11:0] TSFW_EVENT_OFF = 12'h010;
  localparam int TSFW_BIT_AUTO = 2;
  localparam int TSFW_BIT_MANUAL = 3;
  localparam int TSFW_BIT_RUN = 4;
  localparam int TSFW_BIT_DONE = 5;
  localparam int TSFW_BIT_OPT = 6;
  localparam int TSFW_BIT_RSTWAIT = 7;
  localparam int TSFW_BIT_STROBE = 8;
  localparam int TSFW_BIT_CYCLE = 9;
  localparam int TSFW_BIT_TEACH_OK = 13;
  localparam int TSFW_BIT_TEACH_ERR = 14;
  localparam int TSFW_BIT_ADDR_OVER = 15;
  // event register bits (write one to pulse)
  localparam int TSFW_EV_PROG_START = 0;
  localparam int TSFW_EV_PROG_END = 1;
  localparam int TSFW_EV_CODE_OUT = 2;
  localparam int TSFW_EV_TEACH_OK = 3;
  localparam int TSFW_EV_TEACH_ERR = 4;
  localparam int TSFW_EV_ADDR_OVER = 5;
  localparam int TSFW_EV_ADDR_SET = 6;
  localparam int TSFW_EV_PROG_STOP = 7;
  localparam logic [9:0] TSFW_CODE_MAX = 10'h3e7;
  localparam logic [15:0] TSFW_WORD_RESET = 16'h0000;
  localparam logic [31:0] TSFW_ZERO32 = 32'h0000_0000;
  typedef enum logic [1:0] {TSFW_MODE_OTHER, TSFW_MODE_AUTO, TSFW_MODE_MANUAL} tsfw_mode_type;
  // host command levels into the device
  typedef struct packed {
    logic cycle_start;
    logic teach_cmd;
    logic code_reset;
    logic opt_input;
  } tsfw_host_cmd_type;
  // one-cycle unit events
  typedef struct packed {
    logic prog_start;
    logic prog_end;
    logic prog_stop;
    logic code_out;
    logic teach_ok;
    logic teach_err;
    logic addr_over;
    logic addr_set;
    logic opt_wait;
  } tsfw_event_type;
endpackage

// ### rtl/tsfw_flag.sv
// sticky flag with set-over-clear priority
`timescale 1ns/1ps
`default_nettype none
module tsfw_flag (
  input wire logic clk,
  input wire logic resetn,
  input wire logic set,
  input wire logic clr,
  output logic q
);
  logic q_reg;
  logic q_next;
  always_comb begin
    // a set in the clearing cycle is kept
    q_next = set ? 1'b1 : (clr ? 1'b0 : q_reg);
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
    end
  end
  assign q = q_reg;
endmodule
`default_nettype wire

// ### rtl/tsfw_top.sv
// task status flag word with apb register access
`timescale 1ns/1ps
`default_nettype none
module tsfw_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tsfw_pkg::tsfw_host_cmd_type host_cmd,
  output logic [15:0] status_word,
  output logic [15:0] code_word
);
  import tsfw_pkg::*;

  tsfw_mode_type mode_reg;
  tsfw_mode_type mode_next;
  logic run_reg;
  logic run_next;
  logic [9:0] code_reg;
  logic [9:0] code_next;
  logic cs_prev_reg;
  logic cs_prev_next;
  logic teach_prev_reg;
  logic teach_prev_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [15:0] word_reg;
  logic [15:0] word_next;
  logic [15:0] code_out_reg;
  logic [15:0] code_out_next;
  logic opt_wait_reg;
  logic opt_wait_next;
  tsfw_event_type ev;
  logic done_q;
  logic strobe_q;
  logic cycle_q;
  logic teach_ok_q;
  logic teach_err_q;
  logic addr_over_q;
  logic acc_en;
  logic wr_en;
  logic rd_en;
  logic cs_rise;
  logic cs_fall;
  logic teach_fall;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  // codes above the top value are refused, never truncated
  function automatic logic code_ok(input logic [31:0] d);
    code_ok = (d[9:0] <= TSFW_CODE_MAX) && (d[31:10] == 22'h0);
  endfunction

  always_comb begin
    acc_en = psel && penable && !pready_reg;
    wr_en = psel && penable && pwrite && pready_reg;
    rd_en = acc_en && !pwrite;
    ev = '0;
    if (wr_en && hit(paddr, TSFW_EVENT_OFF)) begin
      ev.prog_start = pwdata[TSFW_EV_PROG_START];
      ev.prog_end = pwdata[TSFW_EV_PROG_END];
      ev.prog_stop = pwdata[TSFW_EV_PROG_STOP];
      ev.code_out = pwdata[TSFW_EV_CODE_OUT];
      ev.teach_ok = pwdata[TSFW_EV_TEACH_OK];
      ev.teach_err = pwdata[TSFW_EV_TEACH_ERR];
      ev.addr_over = pwdata[TSFW_EV_ADDR_OVER];
      ev.addr_set = pwdata[TSFW_EV_ADDR_SET];
    end
    cs_rise = host_cmd.cycle_start && !cs_prev_reg;
    cs_fall = !host_cmd.cycle_start && cs_prev_reg;
    teach_fall = !host_cmd.teach_cmd && teach_prev_reg;
  end

  // bus and unit state
  always_comb begin
    mode_next = mode_reg;
    run_next = run_reg;
    code_next = code_reg;
    opt_wait_next = opt_wait_reg;
    cs_prev_next = host_cmd.cycle_start;
    teach_prev_next = host_cmd.teach_cmd;
    prdata_next = TSFW_ZERO32;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    // clear first, so a write in the same cycle wins
    if (host_cmd.opt_input) begin
      opt_wait_next = 1'b0;
    end
    // one wait state: answer one cycle after the access starts
    if (acc_en) begin
      pready_next = 1'b1;
    end
    // write errors ride with pready; status is read only
    if (acc_en && pwrite) begin
      if (hit(paddr, TSFW_CODE_OFF)) begin
        pslverr_next = !code_ok(pwdata);
      end else if (!hit(paddr, TSFW_MODE_OFF) && !hit(paddr, TSFW_CMD_OFF)
          && !hit(paddr, TSFW_EVENT_OFF)) begin
        pslverr_next = 1'b1;
      end
    end
    // writes land at the edge that samples pready high
    if (wr_en) begin
      if (hit(paddr, TSFW_MODE_OFF)) begin
        case (pwdata[1:0])
          2'h1: mode_next = TSFW_MODE_AUTO;
          2'h2: mode_next = TSFW_MODE_MANUAL;
          default: mode_next = TSFW_MODE_OTHER;
        endcase
      end else if (hit(paddr, TSFW_CODE_OFF)) begin
        if (code_ok(pwdata)) begin
          code_next = pwdata[9:0];
        end
      end else if (hit(paddr, TSFW_CMD_OFF)) begin
        opt_wait_next = pwdata[0];
      end
    end
    if (rd_en) begin
      if (hit(paddr, TSFW_STATUS_OFF)) begin
        prdata_next = {16'h0000, word_reg};
      end else if (hit(paddr, TSFW_CODE_OFF)) begin
        prdata_next = {16'h0000, code_out_reg};
      end else if (hit(paddr, TSFW_MODE_OFF)) begin
        prdata_next = {30'h0, mode_reg};
      end else if (hit(paddr, TSFW_CMD_OFF)) begin
        prdata_next = {28'h0, host_cmd};
      end else if (hit(paddr, TSFW_EVENT_OFF)) begin
        prdata_next = TSFW_ZERO32;
      end else begin
        pslverr_next = 1'b1;
      end
    end
    // program runs only in automatic mode
    if (ev.prog_start && mode_reg == TSFW_MODE_AUTO) begin
      run_next = 1'b1;
    end
    if (ev.prog_end || ev.prog_stop || mode_reg != TSFW_MODE_AUTO) begin
      run_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= TSFW_MODE_OTHER;
      run_reg <= 1'b0;
      code_reg <= 10'h000;
      opt_wait_reg <= 1'b0;
      cs_prev_reg <= 1'b0;
      teach_prev_reg <= 1'b0;
      prdata_reg <= TSFW_ZERO32;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      run_reg <= run_next;
      code_reg <= code_next;
      opt_wait_reg <= opt_wait_next;
      cs_prev_reg <= cs_prev_next;
      teach_prev_reg <= teach_prev_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // completion latched; a new start clears it
  tsfw_flag u_done (
    .clk(clk), .resetn(resetn),
    .set(ev.prog_end && run_reg),
    .clr(ev.prog_start),
    .q(done_q)
  );
  tsfw_flag u_strobe (
    .clk(clk), .resetn(resetn),
    .set(ev.code_out),
    .clr(host_cmd.code_reset),
    .q(strobe_q)
  );
  tsfw_flag u_cycle (
    .clk(clk), .resetn(resetn),
    .set(cs_rise),
    .clr(cs_fall),
    .q(cycle_q)
  );
  tsfw_flag u_teach_ok (
    .clk(clk), .resetn(resetn),
    .set(ev.teach_ok && host_cmd.teach_cmd),
    .clr(teach_fall),
    .q(teach_ok_q)
  );
  tsfw_flag u_teach_err (
    .clk(clk), .resetn(resetn),
    .set(ev.teach_err),
    .clr(ev.teach_ok || ev.addr_set),
    .q(teach_err_q)
  );
  tsfw_flag u_addr_over (
    .clk(clk), .resetn(resetn),
    .set(ev.addr_over),
    .clr(ev.teach_ok || ev.addr_set),
    .q(addr_over_q)
  );

  always_comb begin
    word_next = TSFW_WORD_RESET;
    word_next[TSFW_BIT_AUTO] = (mode_reg == TSFW_MODE_AUTO);
    word_next[TSFW_BIT_MANUAL] = (mode_reg == TSFW_MODE_MANUAL);
    word_next[TSFW_BIT_RUN] = run_reg;
    word_next[TSFW_BIT_DONE] = done_q;
    word_next[TSFW_BIT_OPT] = opt_wait_reg;
    word_next[TSFW_BIT_RSTWAIT] = strobe_q;
    word_next[TSFW_BIT_STROBE] = strobe_q;
    word_next[TSFW_BIT_CYCLE] = cycle_q;
    word_next[TSFW_BIT_TEACH_OK] = teach_ok_q;
    word_next[TSFW_BIT_TEACH_ERR] = teach_err_q;
    word_next[TSFW_BIT_ADDR_OVER] = addr_over_q;
    // code reads zero unless strobe on
    code_out_next = strobe_q ? {6'h00, code_reg} : 16'h0000;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      word_reg <= TSFW_WORD_RESET;
      code_out_reg <= 16'h0000;
    end else begin
      word_reg <= word_next;
      code_out_reg <= code_out_next;
    end
  end

  assign status_word = word_reg;
  assign code_word = code_out_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
endmodule
`default_nettype wire

// ### tb/tsfw_top_sva.sv
// checker for the task status flag word ports
`timescale 1ns/1ps
`default_nettype none
module tsfw_top_sva (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire tsfw_pkg::tsfw_host_cmd_type host_cmd,
  input wire logic [15:0] status_word,
  input wire logic [15:0] code_word
);
  import tsfw_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence access_s; psel && penable && !pready; endsequence
  sequence answer_s; pready ##1 !pready; endsequence
  apb_answer_a: assert property (access_s |=> answer_s) else $error("apb answer wrong");
  err_ready_a: assert property (pslverr |-> pready) else $error("stray slave error");
  cycle_set_a: assert property ($rose(host_cmd.cycle_start) |-> ##[1:3] status_word[9])
    else $error("cycle start not seen");
  cycle_clr_a: assert property ($fell(host_cmd.cycle_start) |-> ##[1:3] !status_word[9])
    else $error("cycle flag stuck");
  teach_clr_a: assert property ($fell(host_cmd.teach_cmd) |-> ##[1:3] !status_word[13])
    else $error("teach flag stuck");
  code_clr_a: assert property (host_cmd.code_reset [*4] |-> !status_word[8])
    else $error("strobe stuck");
  strobe_pair_a: assert property (status_word[7] == status_word[8])
    else $error("reset wait differs");
  unused_zero_a: assert property (status_word[1:0] == 2'h0 && status_word[12:10] == 3'h0)
    else $error("unused bit set");
  mode_excl_a: assert property (!(status_word[2] && status_word[3]))
    else $error("two modes");
  done_run_a: assert property ($rose(status_word[5]) |-> $past(status_word[4]))
    else $error("done without run");
  code_range_a: assert property (code_word <= 16'h03e7) else $error("code too big");
endmodule
bind tsfw_top tsfw_top_sva u_sva (.*);
`default_nettype wire

// ### tb/tsfw_host_model.sv
// host controller model driving the command levels
`timescale 1ns/1ps
`default_nettype none
module tsfw_host_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] want,
  output var tsfw_pkg::tsfw_host_cmd_type host_cmd
);
  import tsfw_pkg::*;
  // levels move only after an edge, like a scanned output image
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      host_cmd <= '0;
    end else begin
      host_cmd.cycle_start <= want[3];
      host_cmd.teach_cmd <= want[2];
      host_cmd.code_reset <= want[1];
      host_cmd.opt_input <= want[0];
    end
  end
endmodule
`default_nettype wire

// ### tb/test_task_status_flag_word.sv
// self-checking bench for the task status flag word
`timescale 1ns/1ps
`default_nettype none
module test_task_status_flag_word;
  import tsfw_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er;
  logic [3:0] want = 4'h0;
  tsfw_host_cmd_type host_cmd;
  logic [15:0] status_word, code_word;
  int err_total = 0, n_compared = 0;
  always #5 clk = ~clk;
  tsfw_top u_dut (.*);
  tsfw_host_model u_host (.*);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", pready, 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ev(input logic [7:0] b);
    apb(1'b1, TSFW_EVENT_OFF, {24'h0, b});
  endtask
  // host levels need a few edges to reach the word
  task automatic st(input string nm, input logic [15:0] m, input logic [15:0] e);
    repeat (4) @(posedge clk);
    apb(1'b0, TSFW_STATUS_OFF, 32'h0);
    chk(nm, rd[15:0] & m, e);
    chk(nm, status_word & m, e);
  endtask
  task automatic t_mode();
    for (int m = 1; m < 4; m++) begin
      apb(1'b1, TSFW_MODE_OFF, 32'(m % 3));
      st("mode", 16'h000c, (m == 1) ? 16'h4 : (m == 2) ? 16'h8 : 16'h0);
      apb(1'b0, TSFW_MODE_OFF, 32'h0);
      chk("mode rd", rd, 32'(m % 3));
    end
  endtask
  task automatic t_prog();
    apb(1'b1, TSFW_MODE_OFF, 32'h2);
    ev(8'h01);
    st("run manual", 16'h0030, 16'h0);
    apb(1'b1, TSFW_MODE_OFF, 32'h1);
    ev(8'h02);
    st("done idle", 16'h0030, 16'h0);
    ev(8'h01);
    st("run", 16'h0030, 16'h0010);
    ev(8'h02);
    st("done", 16'h0020, 16'h0020);
    ev(8'h01);
    st("restart", 16'h0030, 16'h0010);
    ev(8'h80);
    st("stopped", 16'h0030, 16'h0);
    ev(8'h01);
    st("run again", 16'h0010, 16'h0010);
    apb(1'b1, TSFW_MODE_OFF, 32'h0);
    st("left auto", 16'h0010, 16'h0);
  endtask
  task automatic t_code();
    apb(1'b1, TSFW_CODE_OFF, 32'h3e8);
    chk("code refused", er, 1'b1);
    apb(1'b1, TSFW_CODE_OFF, 32'h3e7);
    ev(8'h04);
    st("strobe", 16'h0180, 16'h0180);
    chk("code", code_word, 32'h3e7);
    apb(1'b0, TSFW_CODE_OFF, 32'h0);
    chk("code rd", rd, 32'h3e7);
    want[1] <= 1'b1;
    st("code reset", 16'h0180, 16'h0);
    chk("code off", code_word, 32'h0);
    want[1] <= 1'b0;
  endtask
  task automatic t_host();
    want[3] <= 1'b1;
    st("cycle", 16'h0200, 16'h0200);
    want[3] <= 1'b0;
    st("cycle off", 16'h0200, 16'h0);
    want[2] <= 1'b1;
    ev(8'h08);
    st("taught", 16'h2000, 16'h2000);
    want[2] <= 1'b0;
    st("teach off", 16'h2000, 16'h0);
    ev(8'h30);
    st("teach errs", 16'hc000, 16'hc000);
    ev(8'h40);
    st("addr set", 16'hc000, 16'h0);
    ev(8'h30);
    ev(8'h08);
    st("teach ok", 16'he000, 16'h0);
  endtask
  task automatic t_opt();
    apb(1'b1, TSFW_CMD_OFF, 32'h1);
    st("opt wait", 16'h0040, 16'h0040);
    want[0] <= 1'b1;
    st("opt in", 16'h0040, 16'h0);
    apb(1'b0, TSFW_CMD_OFF, 32'h0);
    chk("cmd rd", rd, 32'h1);
    want[0] <= 1'b0;
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped err", er, 1'b1);
    chk("unmapped rd", rd, 32'h0);
    apb(1'b1, TSFW_STATUS_OFF, 32'h1);
    chk("status write", er, 1'b1);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_mode();
    t_prog();
    t_code();
    t_host();
    t_opt();
    tally_and_finish();
  end
  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
